// >>> core/sfb_defs.svh
// constants of the serial flash bus front end: opcodes, status fields, sizes
// assumes inclusion by bare name from the core files
`ifndef SFB_DEFS_SVH
`define SFB_DEFS_SVH
`define SFB_OP_WRSR     8'h01
`define SFB_OP_PROG     8'h02
`define SFB_OP_READ     8'h03
`define SFB_OP_RDSR     8'h05
`define SFB_OP_WREN     8'h06
`define SFB_OP_ER4      8'h20
`define SFB_OP_QPROG    8'h32
`define SFB_OP_DUAL     8'h3b
`define SFB_OP_SECPROG  8'h42
`define SFB_OP_SECLOCK  8'h44
`define SFB_OP_SECREAD  8'h48
`define SFB_OP_ER32     8'h52
`define SFB_OP_QUAD     8'h6b
`define SFB_OP_RDID     8'h9f
`define SFB_OP_ERCHIP   8'hc7
`define SFB_OP_ER64     8'hd8
`define SFB_DUMMY_CLKS  8
`define SFB_PAGE_BYTES  9'h100
`define SFB_MFR_ID      8'h5a
`define SFB_DEV_ID      16'h1234
`define SFB_ST_BUSY     0
`define SFB_ST_WEL      1
`define SFB_ST_PROT     2
`define SFB_ST_LOCK     3
`define SFB_PROT_RST    1'b0
`define SFB_LOCK_RST    3'h0
`endif

// >>> core/sfb_pkg.sv
// types shared by the serial flash bus front end
// assumes nothing beyond the core files
`default_nettype none
package sfb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DUMMY = 3'b011,
        ST_OUT   = 3'b100,
        ST_DATA  = 3'b101,
        ST_SKIP  = 3'b110
    } sfb_state_e;
    typedef enum logic [2:0] {
        K_PROG   = 3'b000,
        K_SECPRG = 3'b001,
        K_ER4    = 3'b010,
        K_ER32   = 3'b011,
        K_ER64   = 3'b100,
        K_ERCHIP = 3'b101
    } sfb_kind_e;
    typedef struct packed {
        sfb_kind_e   kind;
        logic [20:0] addr;
        logic [8:0]  len;
    } sfb_op_s;
    typedef struct packed {
        sfb_state_e  state;
        logic [7:0]  cmd;
        logic [4:0]  bitcnt;
        logic [23:0] addr;
        logic [7:0]  dsr;
        logic [8:0]  pcnt;
        logic [7:0]  pofs;
        logic        wel;
        logic        prot;
        logic [2:0]  lock;
        logic        wp_n;
        logic [7:0]  out_sr;
        logic [3:0]  out_cnt;
        logic [7:0]  rd_byte;
        logic        rd_full;
        logic        rq;
        logic        rq_pend;
        logic [1:0]  idx;
        logic        hold;
        logic [3:0]  lo;
        logic [3:0]  oe;
        logic        pw_en;
        logic [7:0]  pw_addr;
        logic [7:0]  pw_data;
        logic        push;
        sfb_op_s     op;
        logic        active;
    } sfb_ctl_s;
endpackage : sfb_pkg
`default_nettype wire

// >>> core/sfb_page_if.sv
// page buffer port between the front end and its page memory
// assumes both sides run on the system clock
`timescale 1ns/100ps
`default_nettype none
interface sfb_page_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport fill (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface : sfb_page_if
`default_nettype wire

// >>> core/sfb_page_mem.sv
// 256-byte page buffer, one write port, one registered read port
// assumes a single clock and no reset of the contents
`timescale 1ns/100ps
`default_nettype none
module sfb_page_mem (
    input  wire logic i_clk_sys, // system clock
    sfb_page_if.mem   pg         // page port
);
    logic [7:0] mem [0:255];
    logic [7:0] rdata;

    always_ff @(posedge i_clk_sys) begin
        if (pg.wr_en) begin
            mem[pg.wr_addr] <= pg.wr_data;
        end
        rdata <= mem[pg.rd_addr];
    end

    assign pg.rd_data = rdata;
endmodule : sfb_page_mem
`default_nettype wire

// >>> core/sfb_frontend.sv
// serial bus front end of a 16-Mbit serial flash
// assumes pins arrive asynchronously; back end on i_clk_sys answers reads
`timescale 1ns/100ps
`default_nettype none
`include "sfb_defs.svh"
// Contract
// R1 - select high: deselected, standby, output lanes floating
// R2 - while deselected, input lane values are ignored
// R3 - operations start on select fall and end on select rise
// R4 - stay active after select rise until internal program or erase ends
// R5 - command, address and input data sampled on rising clock edges
// R6 - read data changes only on falling clock edges
// R7 - dual and quad reads drive two or four bits per falling edge
// R8 - works with clock idling low or high, modes 0 and 3
// R9 - program accepts 1 to 256 bytes within one page
// R10 - erase of 4, 32, 64 kilobyte blocks and whole array
// R11 - three security pages, each lockable on its own
// R12 - write-protect low keeps protected blocks from change
// R13 - identification read returns maker and device codes
// R14 - addresses select bytes in a two-megabyte space
// R15 - pause input freezes the link, program and erase go on; quad read and quad program ignore pause
// R16 - quad program takes four bits per rising edge on all lanes
// R17 - eight-bit command then 24-bit address, msb first
// R18 - host releases the input lane before device drives it
module sfb_frontend #(
    parameter logic [7:0]  MFR_ID     = `SFB_MFR_ID, // arbitrary value
    parameter logic [15:0] DEV_ID     = `SFB_DEV_ID, // arbitrary value
    parameter int unsigned DUMMY_CLKS = `SFB_DUMMY_CLKS
) (
    input  wire logic        i_clk_sys,            // system clock
    input  wire logic        i_reset,              // async reset
    input  wire logic        i_sck,                // serial clock pin
    input  wire logic        i_cs_n,               // select pin, low active
    input  wire logic        i_data_lane_zero,     // lane 0 in
    input  wire logic        i_data_lane_one,      // lane 1 in
    input  wire logic        i_data_lane_two,      // lane 2 in, write protect
    input  wire logic        i_data_lane_three,    // lane 3 in, pause
    output logic             o_data_lane_zero,     // lane 0 out
    output logic             o_data_lane_one,      // lane 1 out
    output logic             o_data_lane_two,      // lane 2 out
    output logic             o_data_lane_three,    // lane 3 out
    output logic             o_data_lane_zero_oe,  // lane 0 drive
    output logic             o_data_lane_one_oe,   // lane 1 drive
    output logic             o_data_lane_two_oe,   // lane 2 drive
    output logic             o_data_lane_three_oe, // lane 3 drive
    output logic             o_op_valid,           // operation waiting
    output logic [2:0]       o_op_kind,            // operation kind
    output logic [20:0]      o_op_addr,            // operation address
    output logic [8:0]       o_op_len,             // program byte count
    input  wire logic        i_op_ready,           // back end takes op
    input  wire logic        i_busy,               // internal op running
    output logic             o_rd_req,             // read byte request
    output logic [20:0]      o_rd_addr,            // read byte address
    output logic             o_rd_sec,             // read from security page
    input  wire logic        i_rd_valid,           // read byte answer
    input  wire logic [7:0]  i_rd_data,            // read byte data
    input  wire logic [7:0]  i_pg_raddr,           // page buffer address
    output logic [7:0]       o_pg_rdata,           // page buffer data
    output logic             o_active              // not in standby
);
    sfb_pkg::sfb_ctl_s c, n;
    sfb_pkg::sfb_op_s  q0, q1, next_q0, next_q1;
    logic              q0v, q1v, next_q0v, next_q1v;
    logic [2:0]        sck_s, cs_s;
    logic [3:0]        lane_s1, lane_s2;
    logic              sck_rise, sck_fall, cs_fall, cs_rise, act_r, act_f;
    logic              quad_pin, blk, pg_ok, busy, rd_sec, next_rd_sec;
    logic [7:0]        nb, cur;
    logic [2:0]        w;
    logic [4:0]        win;
    logic [1:0]        pg;
    sfb_page_if        pgi ();

    function automatic logic [2:0] lane_width(input logic [7:0] op);
        case (op)
            `SFB_OP_QUAD: lane_width = 3'h4;
            `SFB_OP_DUAL: lane_width = 3'h2;
            default:      lane_width = 3'h1;
        endcase
    endfunction : lane_width

    function automatic logic [7:0] id_byte(input logic [1:0] i);
        case (i)
            2'h0:    id_byte = MFR_ID;
            2'h1:    id_byte = DEV_ID[15:8];
            default: id_byte = DEV_ID[7:0];
        endcase
    endfunction : id_byte

    // pins pass two flops before any logic
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            sck_s   <= 3'h0;
            cs_s    <= 3'h7;
            lane_s1 <= 4'hf;
            lane_s2 <= 4'hf;
        end else begin
            sck_s   <= {sck_s[1:0], i_sck};
            cs_s    <= {cs_s[1:0], i_cs_n};
            lane_s1 <= {i_data_lane_three, i_data_lane_two, i_data_lane_one,
                        i_data_lane_zero};
            lane_s2 <= lane_s1;
        end
    end

    // R8 edges found from either idle level
    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign cs_fall  = ~cs_s[1] & cs_s[2];
    assign cs_rise  = cs_s[1] & ~cs_s[2];
    // R2 edges count only while selected and not paused
    assign act_r    = ~cs_s[1] & (c.state != sfb_pkg::ST_IDLE) & ~c.hold & sck_rise;
    assign act_f    = ~cs_s[1] & (c.state != sfb_pkg::ST_IDLE) & ~c.hold & sck_fall;
    assign quad_pin = (c.state != sfb_pkg::ST_CMD)
                    & (c.cmd == `SFB_OP_QPROG || c.cmd == `SFB_OP_QUAD);
    assign busy     = i_busy | q0v;
    assign pg       = c.addr[9:8];
    assign pg_ok    = (pg != 2'h0) && !c.lock[pg - 2'h1];
    // R12 upper half and chip erase protected while the protect bit is set and write-protect is low
    assign blk      = c.prot & ~c.wp_n & ((c.cmd == `SFB_OP_ERCHIP) | c.addr[20]);

    always_comb begin
        n        = c;
        n.rq     = 1'b0;
        n.push   = 1'b0;
        n.pw_en  = 1'b0;
        w        = lane_width(c.cmd);
        win      = (c.cmd == `SFB_OP_QPROG) ? 5'h4 : 5'h1;
        cur      = (c.out_cnt == 4'h0) ? c.rd_byte : c.out_sr;
        nb       = {c.cmd[6:0], lane_s2[0]};
        // R15 pause starts only with clock low
        if (!cs_s[1] && c.state != sfb_pkg::ST_IDLE && !quad_pin) begin
            n.hold = c.hold ? ~lane_s2[3] : (~lane_s2[3] & ~sck_s[1]);
        end else begin
            n.hold = 1'b0;
        end
        // R13 identification and status come from inside
        if (c.state == sfb_pkg::ST_OUT && !c.rd_full && !c.rq_pend) begin
            case (c.cmd)
                `SFB_OP_RDID: begin
                    n.rd_byte = id_byte(c.idx);
                    n.rd_full = 1'b1;
                    n.idx     = (c.idx == 2'h2) ? 2'h0 : c.idx + 2'h1;
                end
                `SFB_OP_RDSR: begin
                    n.rd_byte                = 8'h00;
                    n.rd_byte[`SFB_ST_BUSY]  = busy;
                    n.rd_byte[`SFB_ST_WEL]   = c.wel;
                    n.rd_byte[`SFB_ST_PROT]  = c.prot;
                    n.rd_byte[`SFB_ST_LOCK+:3] = c.lock;
                    n.rd_full                = 1'b1;
                end
                default: begin
                    n.rq      = 1'b1;
                    n.rq_pend = 1'b1;
                end
            endcase
        end
        if (c.rq_pend && i_rd_valid) begin
            n.rd_byte = i_rd_data;
            n.rd_full = 1'b1;
            n.rq_pend = 1'b0;
            n.addr    = c.addr + 24'h1;
        end
        // R6 R7 output lanes move on falling edges only
        if (act_f && c.state == sfb_pkg::ST_OUT) begin
            if (c.out_cnt == 4'h0) begin
                n.rd_full = 1'b0;
            end
            case (w)
                3'h4:    begin n.lo = cur[7:4]; n.oe = 4'hf; end
                3'h2:    begin n.lo = {2'b00, cur[7:6]}; n.oe = 4'h3; end
                default: begin n.lo = {2'b00, cur[7], 1'b0}; n.oe = 4'h2; end
            endcase
            n.out_sr  = cur << w;
            n.out_cnt = ((c.out_cnt == 4'h0) ? 4'h8 : c.out_cnt) - {1'b0, w};
        end
        // R5 R17 serial input taken on rising edges, msb first
        if (act_r) begin
            case (c.state)
                sfb_pkg::ST_CMD: begin
                    n.cmd    = nb;
                    n.bitcnt = c.bitcnt + 5'h1;
                    if (c.bitcnt == 5'h7) begin
                        n.bitcnt = 5'h0;
                        n.wp_n   = lane_s2[2];
                        n.idx    = 2'h0;
                        case (nb)
                            `SFB_OP_WREN: begin
                                n.wel   = 1'b1;
                                n.state = sfb_pkg::ST_SKIP;
                            end
                            `SFB_OP_RDSR, `SFB_OP_RDID: n.state = sfb_pkg::ST_OUT;
                            `SFB_OP_WRSR:   n.state = sfb_pkg::ST_DATA;
                            `SFB_OP_ERCHIP: n.state = sfb_pkg::ST_SKIP;
                            `SFB_OP_READ, `SFB_OP_DUAL, `SFB_OP_QUAD, `SFB_OP_PROG,
                            `SFB_OP_QPROG, `SFB_OP_ER4, `SFB_OP_ER32, `SFB_OP_ER64,
                            `SFB_OP_SECPROG, `SFB_OP_SECREAD, `SFB_OP_SECLOCK:
                                n.state = sfb_pkg::ST_ADDR;
                            default: n.state = sfb_pkg::ST_SKIP;
                        endcase
                    end
                end
                sfb_pkg::ST_ADDR: begin
                    n.addr   = {c.addr[22:0], lane_s2[0]};
                    n.bitcnt = c.bitcnt + 5'h1;
                    if (c.bitcnt == 5'h17) begin
                        n.bitcnt = 5'h0;
                        case (c.cmd)
                            `SFB_OP_READ, `SFB_OP_SECREAD: n.state = sfb_pkg::ST_OUT;
                            `SFB_OP_DUAL, `SFB_OP_QUAD:    n.state = sfb_pkg::ST_DUMMY;
                            `SFB_OP_PROG, `SFB_OP_QPROG, `SFB_OP_SECPROG:
                                n.state = sfb_pkg::ST_DATA;
                            default: n.state = sfb_pkg::ST_SKIP;
                        endcase
                    end
                end
                sfb_pkg::ST_DUMMY: begin
                    n.bitcnt = c.bitcnt + 5'h1;
                    if (c.bitcnt == 5'(DUMMY_CLKS - 1)) begin
                        n.bitcnt = 5'h0;
                        n.state  = sfb_pkg::ST_OUT;
                    end
                end
                sfb_pkg::ST_DATA: begin
                    // R16 quad program takes all four lanes
                    n.dsr    = (c.cmd == `SFB_OP_QPROG) ? {c.dsr[3:0], lane_s2}
                                                         : {c.dsr[6:0], lane_s2[0]};
                    n.bitcnt = c.bitcnt + win;
                    if (c.bitcnt + win == 5'h8) begin
                        n.bitcnt  = 5'h0;
                        n.pw_en   = (c.cmd != `SFB_OP_WRSR);
                        n.pw_addr = c.addr[7:0] + c.pofs;
                        n.pw_data = n.dsr;
                        n.pofs    = c.pofs + 8'h1;
                        // R9 count stops at one page
                        if (c.pcnt != `SFB_PAGE_BYTES) begin
                            n.pcnt = c.pcnt + 9'h1;
                        end
                    end
                end
                sfb_pkg::ST_SKIP: n.bitcnt = c.bitcnt + 5'h1;
                default: ;
            endcase
        end
        // R3 select fall opens a frame
        if (cs_fall) begin
            n.state   = sfb_pkg::ST_CMD;
            n.bitcnt  = 5'h0;
            n.cmd     = 8'h00;
            n.out_cnt = 4'h0;
            n.rd_full = 1'b0;
            n.rq_pend = 1'b0;
            n.pcnt    = 9'h0;
            n.pofs    = 8'h0;
        end
        // R3 select rise closes the frame and commits it
        if (cs_rise) begin
            n.state   = sfb_pkg::ST_IDLE;
            n.rq_pend = 1'b0;
            n.op.addr = c.addr[20:0];
            n.op.len  = c.pcnt;
            if (c.bitcnt[2:0] == 3'h0 && c.wel && !q1v) begin
                case (c.cmd)
                    // R10 three block sizes and whole array
                    `SFB_OP_ER4, `SFB_OP_ER32, `SFB_OP_ER64, `SFB_OP_ERCHIP: begin
                        n.push    = (c.state == sfb_pkg::ST_SKIP) && !blk;
                        n.op.kind = (c.cmd == `SFB_OP_ER4)  ? sfb_pkg::K_ER4 :
                                    (c.cmd == `SFB_OP_ER32) ? sfb_pkg::K_ER32 :
                                    (c.cmd == `SFB_OP_ER64) ? sfb_pkg::K_ER64 :
                                                              sfb_pkg::K_ERCHIP;
                    end
                    `SFB_OP_PROG, `SFB_OP_QPROG: begin
                        n.push    = (c.state == sfb_pkg::ST_DATA) && c.pcnt != 9'h0 && !blk;
                        n.op.kind = sfb_pkg::K_PROG;
                    end
                    // R11 locked security pages refuse programming
                    `SFB_OP_SECPROG: begin
                        n.push    = (c.state == sfb_pkg::ST_DATA) && c.pcnt != 9'h0 && pg_ok;
                        n.op.kind = sfb_pkg::K_SECPRG;
                    end
                    `SFB_OP_SECLOCK: begin
                        if (c.state == sfb_pkg::ST_SKIP && pg != 2'h0) begin
                            n.lock[pg - 2'h1] = 1'b1;
                        end
                    end
                    `SFB_OP_WRSR: begin
                        if (c.state == sfb_pkg::ST_DATA && c.pcnt != 9'h0
                                && !(c.prot && !c.wp_n)) begin
                            n.prot = c.dsr[`SFB_ST_PROT];
                        end
                    end
                    default: ;
                endcase
            end
            case (c.cmd)
                `SFB_OP_ER4, `SFB_OP_ER32, `SFB_OP_ER64, `SFB_OP_ERCHIP, `SFB_OP_PROG,
                `SFB_OP_QPROG, `SFB_OP_SECPROG, `SFB_OP_SECLOCK, `SFB_OP_WRSR:
                    n.wel = 1'b0;
                default: ;
            endcase
        end
        // R1 R15 lanes float when deselected or paused
        if (cs_s[1] || c.hold) begin
            n.oe = 4'h0;
        end
        // R4 active until queued and running work is done
        n.active = ~cs_s[1] | i_busy | q0v | q1v | c.push | n.push;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            c      <= '0;
            c.prot <= `SFB_PROT_RST;
            c.lock <= `SFB_LOCK_RST;
            c.wp_n <= 1'b1;
            rd_sec <= 1'b0;
        end else begin
            c <= n;
            rd_sec <= next_rd_sec;
        end
    end

    // two-entry operation buffer, head drives the ports
    always_comb begin
        next_q0v = q0v;
        next_q1v = q1v;
        next_q0  = q0;
        next_q1  = q1;
        if (q0v && i_op_ready) begin
            next_q0v = q1v;
            next_q0  = q1;
            next_q1v = 1'b0;
        end
        if (c.push) begin
            if (!next_q0v) begin
                next_q0v = 1'b1;
                next_q0  = c.op;
            end else begin
                next_q1v = 1'b1;
                next_q1  = c.op;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            q0v <= 1'b0;
            q1v <= 1'b0;
            q0  <= '0;
            q1  <= '0;
        end else begin
            q0v <= next_q0v;
            q1v <= next_q1v;
            q0  <= next_q0;
            q1  <= next_q1;
        end
    end

    assign pgi.wr_en   = c.pw_en;
    assign pgi.wr_addr = c.pw_addr;
    assign pgi.wr_data = c.pw_data;
    assign pgi.rd_addr = i_pg_raddr;

    sfb_page_mem sfb_page_mem_i (
        .i_clk_sys (i_clk_sys),
        .pg        (pgi.mem)
    );

    assign {o_data_lane_three, o_data_lane_two, o_data_lane_one, o_data_lane_zero} = c.lo;
    assign {o_data_lane_three_oe, o_data_lane_two_oe, o_data_lane_one_oe,
            o_data_lane_zero_oe} = c.oe;
    assign o_op_valid = q0v;
    assign o_op_kind  = q0.kind;
    assign o_op_addr  = q0.addr;
    assign o_op_len   = q0.len;
    assign o_rd_req   = c.rq;
    // R14 21-bit byte address
    assign o_rd_addr  = c.addr[20:0];
    assign next_rd_sec = (n.cmd == `SFB_OP_SECREAD);
    assign o_rd_sec   = rd_sec;
    assign o_pg_rdata = pgi.rd_data;
    assign o_active   = c.active;

    default clocking dc @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    deselect_float_a: assert property (cs_s[1] |=> c.oe == 4'h0) // R1
        else $error("lanes driven while deselected");
    deselect_idle_a: assert property (cs_s[1] && cs_s[2] |=> c.state == sfb_pkg::ST_IDLE) // R2
        else $error("frame state while deselected");
    frame_open_a: assert property (c.state == sfb_pkg::ST_IDLE && !cs_fall |=>
        c.state == sfb_pkg::ST_IDLE) // R3
        else $error("frame opened without select fall");
    busy_active_a: assert property (i_busy |=> o_active) // R4
        else $error("standby during internal operation");
    rise_sample_a: assert property (act_r && c.state == sfb_pkg::ST_CMD |=>
        c.cmd[0] == $past(lane_s2[0])) // R5
        else $error("command bit not taken on rising edge");
    fall_only_a: assert property (!act_f |=> $stable(c.lo)) // R6
        else $error("output lanes moved off a falling edge");
    quad_lanes_a: assert property (act_f && c.state == sfb_pkg::ST_OUT
        && c.cmd == `SFB_OP_QUAD && !cs_s[1] |=> c.oe == 4'hf) // R7
        else $error("quad read not on four lanes");
    prog_len_a: assert property (o_op_valid && o_op_kind == 3'h0 |->
        o_op_len != 9'h0 && o_op_len <= `SFB_PAGE_BYTES) // R9
        else $error("program length outside one page");
    sec_lock_a: assert property (c.push && c.op.kind == sfb_pkg::K_SECPRG |->
        pg_ok) // R11
        else $error("locked security page programmed");
    wp_block_a: assert property (c.push && c.op.kind != sfb_pkg::K_SECPRG |->
        $past(!blk)) // R12
        else $error("protected block modified");
    hold_float_a: assert property (c.hold |=> c.oe == 4'h0 ##1 c.oe == 4'h0 || !c.hold) // R15
        else $error("lanes driven during pause");
endmodule : sfb_frontend
`default_nettype wire

// >>> testbench/sfb_host_model.sv
// host spi controller model, modes 0 and 3, drives select, clock, lane 0, pause
// assumes the bench feeds lane 1 back as the read input
`timescale 1ns/100ps
`default_nettype none
module sfb_host_model (
    output logic      o_sck,  // serial clock
    output logic      o_cs_n, // select, low active
    output logic      o_mosi, // lane 0 drive
    output logic      o_hold_n, // lane 3 drive, pause low
    input  wire logic i_miso  // lane 1 seen
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        o_hold_n = 1'b1;
    end
    // framed, msb first; idle_hi gives mode 3
    task automatic frame(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$],
                         input logic idle_hi = 1'b0, input int hold_at = -1);
        logic [7:0] b;
        rx = {};
        o_sck = idle_hi;
        #80 o_cs_n = 1'b0;
        #80;
        for (int i = 0; i < tx.size() + nrx; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h00;
            // pause with clock low in mode 0; the stray clock pulse must be ignored
            if (i == hold_at) begin
                o_hold_n = 1'b0;
                #80 o_sck = 1'b1;
                #80 o_sck = 1'b0;
                #80 o_hold_n = 1'b1;
                #80;
            end
            for (int k = 7; k >= 0; k--) begin
                o_mosi = b[k];
                if (idle_hi)
                    o_sck = 1'b0;
                #80 o_sck = 1'b1;
                b[k] = i_miso;
                #80;
                if (!idle_hi)
                    o_sck = 1'b0;
            end
            if (i >= tx.size())
                rx.push_back(b);
        end
        #80 o_cs_n = 1'b1;
        // released lane shows no stale value
        o_mosi = ~o_mosi;
        #200;
    endtask : frame
endmodule : sfb_host_model
`default_nettype wire

// >>> testbench/sfb_frontend_bench.sv
// bench of the serial flash front end: host model, back end stand-in
// assumes the core files and sfb_defs.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "sfb_defs.svh"
module sfb_frontend_bench;
    logic        i_clk_sys = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_op_ready = 1'b0;
    logic        i_rd_valid = 1'b0;
    logic [7:0]  i_rd_data = 8'h00;
    logic        i_busy = 1'b0;
    logic        sck, cs_n, mosi, hold_n, lane1, op_valid, rd_req, active;
    logic [3:0]  oe;
    logic [7:0]  pg_raddr = 8'h02;
    logic [7:0]  pg_rdata;
    logic [2:0]  op_kind;
    logic [20:0] op_addr, rd_addr;
    logic [8:0]  op_len;
    logic [7:0]  rx[$];
    logic [32:0] expq[$];
    logic [32:0] e;
    int          fails = 0;
    int          compares = 0;
    int          seed = 65;
    always #2.5 i_clk_sys = ~i_clk_sys;
    // released lane 1 shows the inverse of its last value
    sfb_host_model sfb_host_model_i (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
        .o_hold_n(hold_n), .i_miso(oe[1] ? lane1 : ~lane1));
    sfb_frontend sfb_frontend_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_sck(sck),
        .i_cs_n(cs_n), .i_data_lane_zero(mosi), .i_data_lane_one(1'b1),
        .i_data_lane_two(1'b1), .i_data_lane_three(hold_n), .o_data_lane_zero(),
        .o_data_lane_one(lane1), .o_data_lane_two(), .o_data_lane_three(),
        .o_data_lane_zero_oe(oe[0]), .o_data_lane_one_oe(oe[1]), .o_data_lane_two_oe(oe[2]),
        .o_data_lane_three_oe(oe[3]), .o_op_valid(op_valid), .o_op_kind(op_kind),
        .o_op_addr(op_addr), .o_op_len(op_len), .i_op_ready(i_op_ready), .i_busy(i_busy),
        .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_rd_sec(), .i_rd_valid(i_rd_valid),
        .i_rd_data(i_rd_data), .i_pg_raddr(pg_raddr), .o_pg_rdata(pg_rdata), .o_active(active));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // back end: random take, read answer one cycle after request
    always @(posedge i_clk_sys) begin
        i_op_ready <= 1'($random(seed));
        i_busy <= op_valid && i_op_ready;
        i_rd_valid <= rd_req;
        i_rd_data <= rd_addr[7:0] ^ 8'h3c;
        if (op_valid && i_op_ready) begin
            e = (expq.size() > 0) ? expq.pop_front() : 33'h1ffffffff;
            check({9'h0, op_kind, (e[32:30] == 3'h5) ? 21'h0 : op_addr}, {9'h0, e[32:9]});
            if (e[32:30] == 3'h0)
                check({24'h0, op_len}, {24'h0, e[8:0]});
        end
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        sfb_host_model_i.frame('{8'h9f}, 3, rx, 1'b1);
        check({9'h0, rx[0], rx[1], rx[2]}, {9'h0, `SFB_MFR_ID, `SFB_DEV_ID});
        sfb_host_model_i.frame('{8'h03, 8'h00, 8'h00, 8'ha5}, 2, rx, 1'b0, 2);
        check({17'h0, rx[0], rx[1]}, {17'h0, 8'ha5 ^ 8'h3c, 8'ha6 ^ 8'h3c});
        check({29'h0, oe}, 33'h0);
        // lane 1 carries bits 5 and 1 of bytes 10..13 xor 3c
        sfb_host_model_i.frame('{8'h6b, 8'h00, 8'h00, 8'h10, 8'h00}, 1, rx);
        check({25'h0, rx[0]}, {25'h0, 8'haf});
        sfb_host_model_i.frame('{8'h06}, 0, rx);
        expq.push_back({3'h0, 21'h001000, 9'h003});
        sfb_host_model_i.frame('{8'h02, 8'h00, 8'h10, 8'h00, 8'h11, 8'h22, 8'h33}, 0, rx);
        check({25'h0, pg_rdata}, {25'h0, 8'h33});
        for (int i = 0; i < 4; i++) begin
            sfb_host_model_i.frame('{8'h06}, 0, rx);
            expq.push_back({3'(i + 2), (i == 3) ? 21'h0 : 21'h003000, 9'h000});
            if (i == 3)
                sfb_host_model_i.frame('{8'hc7}, 0, rx);
            else
                sfb_host_model_i.frame('{(i == 0) ? 8'h20 : (i == 1) ? 8'h52 : 8'hd8,
                                        8'h00, 8'h30, 8'h00}, 0, rx);
        end
        for (int n = 0; n < 1000 && expq.size() > 0; n++)
            @(posedge i_clk_sys);
        repeat (4) @(posedge i_clk_sys);
        #1 check({32'h0, active}, 33'h0);
        if (expq.size() > 0)
            fails++;
        results();
    end
    initial begin
        #200000;
        fails++;
        results();
    end
endmodule : sfb_frontend_bench
`default_nettype wire
